/* File: src/reset_sequencer.sv */
`timescale 1ns/1ps
module reset_sequencer #(
    parameter int WDT_SYSTEM_CYCLES = reset_seq_pkg::WDT_SYSTEM_COUNT,
    parameter int WDT_SHORT_CYCLES = reset_seq_pkg::WDT_SHORT_COUNT,
    parameter int SYS_CYCLES = reset_seq_pkg::SYS_CLK_COUNT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watchdog oscillator cycle enable
    input wire logic wdt_osc_tick,
    // Reset request sources
    input wire reset_seq_pkg::reset_sources_t sources,
    input wire logic [7:0] debugger_control_register,
    // Reset outputs
    output logic core_reset,
    output logic periph_reset,
    output logic debugger_reset,
    output logic ctrl_reg_load,
    output logic sys_clk_enable,
    // Reset vector fetch
    output logic vec_rd_en,
    output logic [15:0] vec_addr,
    input wire logic [7:0] vec_data,
    output logic pc_load,
    output logic [15:0] pc_value,
    // Status
    output logic reset_is_system,
    output reset_seq_pkg::reset_cause_t reset_cause
);
    import reset_seq_pkg::*;

    seq_state_t state_reg;
    seq_state_t state_next;
    logic is_system_reg;
    logic is_system_next;
    logic dbg_bit_prev_reg;
    logic dbg_edge;
    logic pin_active;
    logic stop_debug_low;
    logic wdt_reset_req;
    logic sys_req;
    logic short_req;
    logic any_req;
    logic in_reset;
    logic wdt_done;
    logic sys_done;
    logic sys_restart;
    logic pc_load_reg;
    logic [15:0] vec_addr_reg;
    logic [15:0] pc_value_reg;
    logic [WDT_CNT_W-1:0] wdt_target;
    reset_cause_t cause_reg;
    reset_cause_t cause_now;

    // Parameter sanity
    initial begin
        if (WDT_SYSTEM_CYCLES < 1 || WDT_SYSTEM_CYCLES >= (1 << WDT_CNT_W))
            $error("reset_sequencer: WDT_SYSTEM_CYCLES out of range");
        if (WDT_SHORT_CYCLES < 1 || WDT_SHORT_CYCLES > WDT_SYSTEM_CYCLES)
            $error("reset_sequencer: WDT_SHORT_CYCLES out of range");
        if (SYS_CYCLES < 1 || SYS_CYCLES >= (1 << SYS_CNT_W))
            $error("reset_sequencer: SYS_CYCLES out of range");
    end

    // Debugger reset bit, acted on at its rising edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dbg_bit_prev_reg <= 1'b0;
        end else begin
            dbg_bit_prev_reg <= debugger_control_register[DBG_CTL_RESET_BIT];
        end
    end

    assign dbg_edge = debugger_control_register[DBG_CTL_RESET_BIT] && !dbg_bit_prev_reg;

    // Source classification by operating mode
    always_comb begin
        pin_active = !sources.ext_reset_n;
        stop_debug_low = sources.stop_mode && !sources.debug_pin;
        wdt_reset_req = !sources.stop_mode && sources.wdt_timeout && sources.wdt_reset_cfg;
        sys_req = sources.por_bor
            || dbg_edge
            || (sources.stop_mode && pin_active)
            || stop_debug_low;
        short_req = !sources.stop_mode && pin_active
            || wdt_reset_req;
        any_req = sys_req || short_req;
    end

    // Causes raised this cycle
    always_comb begin
        cause_now.por_bor = sources.por_bor;
        cause_now.watchdog = wdt_reset_req;
        cause_now.ext_pin = pin_active;
        cause_now.debugger = dbg_edge;
        cause_now.debug_pin = stop_debug_low;
    end

    assign in_reset = (state_reg != ST_RUN);

    // Reset type; a short request downgrades a system sequence except during the watchdog tick count
    always_comb begin
        is_system_next = is_system_reg;
        if (sys_req) begin
            is_system_next = 1'b1;
        end else if (short_req && !in_reset) begin
            is_system_next = 1'b0;
        end else if (short_req && state_reg != ST_WDT_COUNT) begin
            is_system_next = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            is_system_reg <= 1'b1;
        end else begin
            is_system_reg <= is_system_next;
        end
    end

    // Cause record: replaced on a fresh sequence, accumulated during one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cause_reg <= CAUSE_POWER_ON;
        end else if (any_req && !in_reset) begin
            cause_reg <= cause_now;
        end else if (any_req) begin
            cause_reg <= cause_reg | cause_now;
        end
    end

    // Watchdog tick count target follows the reset type
    assign wdt_target = is_system_reg ? WDT_CNT_W'(WDT_SYSTEM_CYCLES)
                                      : WDT_CNT_W'(WDT_SHORT_CYCLES);

    // Watchdog oscillator cycle counter, restarted by any request
    tick_counter #(
        .WIDTH(WDT_CNT_W)
    ) wdt_counter (
        .clk(clk),
        .rst(rst),
        .restart(any_req),
        .tick(wdt_osc_tick && state_reg == ST_WDT_COUNT),
        .target(wdt_target),
        .done(wdt_done)
    );

    assign sys_restart = any_req || state_reg != ST_SYS_COUNT;

    // System clock cycle counter; counting 0 to SYS_CYCLES-1 gives exactly SYS_CYCLES cycles
    tick_counter #(
        .WIDTH(SYS_CNT_W)
    ) sys_counter (
        .clk(clk),
        .rst(rst),
        .restart(sys_restart),
        .tick(1'b1),
        .target(SYS_CNT_W'(SYS_CYCLES - 1)),
        .done(sys_done)
    );

    // Sequencer state transitions
    always_comb begin
        state_next = state_reg;
        if (any_req) begin
            state_next = ST_WDT_COUNT;
        end else begin
            unique case (state_reg)
                ST_WDT_COUNT: begin
                    if (wdt_done) state_next = ST_SYS_COUNT;
                end
                ST_SYS_COUNT: begin
                    if (sys_done) state_next = ST_FETCH_HI;
                end
                ST_FETCH_HI: begin
                    state_next = ST_FETCH_LO;
                end
                ST_FETCH_LO: begin
                    state_next = ST_RUN;
                end
                ST_RUN: begin
                    state_next = ST_RUN;
                end
                default: begin
                    state_next = ST_WDT_COUNT;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_WDT_COUNT;
        end else begin
            state_reg <= state_next;
        end
    end

    // Vector address registered from the next state, so it is valid in the same state as the read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vec_addr_reg <= VECTOR_ADDR_HI;
        end else if (state_next == ST_FETCH_LO) begin
            vec_addr_reg <= VECTOR_ADDR_LO;
        end else begin
            vec_addr_reg <= VECTOR_ADDR_HI;
        end
    end

    // Vector bytes, high then low, captured into the program counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_value_reg <= PC_RESET_VALUE;
        end else if (!any_req && state_reg == ST_FETCH_HI) begin
            pc_value_reg[15:8] <= vec_data;
        end else if (!any_req && state_reg == ST_FETCH_LO) begin
            pc_value_reg[7:0] <= vec_data;
        end
    end

    // One-cycle program counter load as the core is released
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_load_reg <= 1'b0;
        end else begin
            pc_load_reg <= !any_req && state_reg == ST_FETCH_LO;
        end
    end

    // Core and peripherals idle through counts and vector fetch
    assign core_reset = in_reset;
    assign periph_reset = in_reset;
    assign ctrl_reg_load = in_reset;
    // System clock held off during the watchdog tick count
    assign sys_clk_enable = (state_reg != ST_WDT_COUNT);
    // Debugger spared when its own bit was the only cause
    assign debugger_reset = in_reset && (cause_reg != 5'h02);
    assign vec_rd_en = (state_reg == ST_FETCH_HI) || (state_reg == ST_FETCH_LO);
    assign vec_addr = vec_addr_reg;
    assign pc_load = pc_load_reg;
    assign pc_value = pc_value_reg;
    assign reset_is_system = is_system_reg;
    assign reset_cause = cause_reg;

endmodule : reset_sequencer

/* File: src/reset_seq_pkg.sv */
package reset_seq_pkg;

    // Watchdog oscillator tick counts and system clock count
    localparam int WDT_SYSTEM_COUNT = 514;
    localparam int WDT_SHORT_COUNT = 66;
    localparam int SYS_CLK_COUNT = 16;
    localparam int WDT_CNT_W = 10;
    localparam int SYS_CNT_W = 5;

    // Reset vector location in program memory
    localparam logic [15:0] VECTOR_ADDR_HI = 16'h0002;
    localparam logic [15:0] VECTOR_ADDR_LO = 16'h0003;
    localparam logic [15:0] PC_RESET_VALUE = 16'h0000;

    // Debugger control register field
    localparam int DBG_CTL_RESET_BIT = 1;

    // Reset request inputs
    typedef struct packed {
        logic por_bor;
        logic wdt_timeout;
        logic wdt_reset_cfg;
        logic ext_reset_n;
        logic debug_pin;
        logic stop_mode;
    } reset_sources_t;

    // Causes seen in the current or last sequence
    typedef struct packed {
        logic por_bor;
        logic watchdog;
        logic ext_pin;
        logic debugger;
        logic debug_pin;
    } reset_cause_t;

    localparam reset_cause_t CAUSE_POWER_ON = 5'h10;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_WDT_COUNT = 5'h01,
        ST_SYS_COUNT = 5'h02,
        ST_FETCH_HI = 5'h04,
        ST_FETCH_LO = 5'h08,
        ST_RUN = 5'h10
    } seq_state_t;

endpackage : reset_seq_pkg

/* File: src/tick_counter.sv */
`timescale 1ns/1ps
module tick_counter #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic restart,
    input wire logic tick,
    input wire logic [WIDTH-1:0] target,
    // Status
    output logic done
);
    import reset_seq_pkg::*;

    logic [WIDTH-1:0] count_reg;

    initial begin
        if (WIDTH < 1) $error("tick_counter: WIDTH must be positive");
    end

    // Count enable ticks up to the target, clear on restart
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (restart) begin
            count_reg <= '0;
        end else if (tick && !done) begin
            count_reg <= count_reg + WIDTH'(1);
        end
    end

    assign done = (count_reg == target);

endmodule : tick_counter

/* File: tb/prog_mem_model.sv */
`timescale 1ns/1ps
module prog_mem_model (
    // Clock
    input wire logic clk,
    // Vector read port
    input wire logic rd_en,
    input wire logic [15:0] addr,
    input wire logic [7:0] hi,
    input wire logic [7:0] lo,
    output logic [7:0] data,
    // Watchdog oscillator
    output logic tick
);
    logic [2:0] div = 3'h0;
    logic [7:0] junk = 8'hA5;

    // Free-running watchdog oscillator, one tick in five clocks
    always @(posedge clk) begin
        div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
        junk <= ~junk ^ {7'h00, div[0]};
    end

    // Vector bytes only while read, a changing pattern otherwise
    assign tick = (div == 3'h4);
    assign data = !rd_en ? junk : (addr == 16'h0002) ? hi : (addr == 16'h0003) ? lo : junk;
endmodule : prog_mem_model

/* File: tb/reset_sequencer_assertions.sv */
`timescale 1ns/1ps
module reset_sequencer_assertions #(
    parameter int SYS_CYCLES = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Requests
    input wire reset_seq_pkg::reset_sources_t sources,
    input wire logic [7:0] debugger_control_register,
    // Reset outputs
    input wire logic core_reset,
    input wire logic periph_reset,
    input wire logic debugger_reset,
    input wire logic ctrl_reg_load,
    input wire logic sys_clk_enable,
    // Vector fetch
    input wire logic vec_rd_en,
    input wire logic [15:0] vec_addr,
    input wire logic [7:0] vec_data,
    input wire logic pc_load,
    input wire logic [15:0] pc_value,
    input wire logic reset_is_system
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Reset output relations
    a_idle_same: assert property (core_reset == periph_reset)
        else $error("core and peripheral resets differ");
    a_load_reset: assert property (!core_reset |-> !ctrl_reg_load)
        else $error("register load outside reset");
    a_idle_clock: assert property ($rose(sys_clk_enable) |-> core_reset[*4])
        else $error("core left idle too early");
    a_clk_fetch: assert property ($rose(vec_rd_en) |-> $past(sys_clk_enable, SYS_CYCLES))
        else $error("fetch before system clock count");
    a_fetch_order: assert property (vec_rd_en && vec_addr == 16'h0002
        |=> vec_rd_en && vec_addr == 16'h0003 ##1 !core_reset)
        else $error("vector fetch order wrong");
    a_pc_release: assert property ($fell(core_reset) |-> pc_load)
        else $error("no program counter load at release");
    a_pc_value: assert property (pc_load |-> pc_value == {$past(vec_data, 2), $past(vec_data)})
        else $error("program counter value wrong");
    a_por_system: assert property (sources.por_bor |=> core_reset && reset_is_system)
        else $error("power-on not a system reset");
    a_pin_short: assert property (!sources.ext_reset_n && !sources.stop_mode && !sources.por_bor
        && !core_reset |=> core_reset && !reset_is_system)
        else $error("reset pin not a short reset");
    a_stop_dbg: assert property (sources.stop_mode && !sources.debug_pin
        |=> core_reset && reset_is_system)
        else $error("debug pin in stop not a system reset");
    a_dbg_spared: assert property ($rose(debugger_control_register[1]) && sources[5:1] == 5'h07
        && !core_reset |=> core_reset && reset_is_system && !debugger_reset)
        else $error("debugger reset wrong");

    // Main scenarios
    c_release: cover property ($fell(core_reset));
    c_stop_dbg: cover property (sources.stop_mode && !sources.debug_pin);
    c_dbg_bit: cover property ($rose(debugger_control_register[1]));
endmodule : reset_sequencer_assertions

bind reset_sequencer reset_sequencer_assertions #(.SYS_CYCLES(SYS_CYCLES)) chk_i (
    .clk(clk), .rst(rst), .sources(sources),
    .debugger_control_register(debugger_control_register),
    .core_reset(core_reset), .periph_reset(periph_reset), .debugger_reset(debugger_reset),
    .ctrl_reg_load(ctrl_reg_load), .sys_clk_enable(sys_clk_enable), .vec_rd_en(vec_rd_en),
    .vec_addr(vec_addr), .vec_data(vec_data), .pc_load(pc_load), .pc_value(pc_value),
    .reset_is_system(reset_is_system)
);

/* File: tb/reset_sequencer_tb.sv */
`timescale 1ns/1ps
module reset_sequencer_tb;
    import reset_seq_pkg::*;
    localparam int NSYS = 20;
    localparam int NSHORT = 6;
    localparam int NCLK = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tick, core_reset, sys_en, rd_en, pc_load, is_sys;
    reset_sources_t src = 6'h0E;
    logic [7:0] dbg = 8'h00;
    logic [7:0] hi = 8'h12;
    logic [7:0] lo = 8'h34;
    logic [7:0] vdata;
    logic [15:0] vaddr, pc_value;
    reset_cause_t cause;
    logic [22:0] q[$];
    logic [22:0] n;
    int errors = 0;
    int tests_run = 0;
    int ticks = 0;
    int clks = 0;
    logic [5:0] srcs[9] = '{6'h2E, 6'h1E, 6'h0A, 6'h0E, 6'h0B, 6'h0D, 6'h2F, 6'h1F, 6'h2A};
    logic [6:0] exps[9] = '{7'h50, 7'h08, 7'h04, 7'h42, 7'h44, 7'h41, 7'h50, 7'h00, 7'h5F};

    reset_sequencer #(.WDT_SYSTEM_CYCLES(NSYS), .WDT_SHORT_CYCLES(NSHORT), .SYS_CYCLES(NCLK))
        reset_sequencer_i (.clk(clk), .rst(rst), .wdt_osc_tick(tick), .sources(src),
        .debugger_control_register(dbg), .core_reset(core_reset), .periph_reset(),
        .debugger_reset(), .ctrl_reg_load(), .sys_clk_enable(sys_en), .vec_rd_en(rd_en),
        .vec_addr(vaddr), .vec_data(vdata), .pc_load(pc_load), .pc_value(pc_value),
        .reset_is_system(is_sys), .reset_cause(cause));
    prog_mem_model prog_mem_model_i (.clk(clk), .rd_en(rd_en), .addr(vaddr), .hi(hi),
        .lo(lo), .data(vdata), .tick(tick));

    // Clock
    always #2 clk = ~clk;

    // Compare one result
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Verdict
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim

    // Pulse one request, plus a power-on request 8 cycles later if mid, note the outcome, wait for release
    task automatic req(input logic [5:0] s, input logic [6:0] e, input bit mid);
        @(negedge clk);
        hi = 8'($urandom);
        lo = 8'($urandom);
        if (e[4:0] != 5'h00) q.push_back({e, hi, lo});
        src = s;
        dbg = {6'h00, e == 7'h42, 1'b0};
        @(negedge clk);
        src[5:1] = 5'h07;
        dbg = 8'h00;
        if (mid) begin
            repeat (8) @(negedge clk);
            src = 6'h2E;
            @(negedge clk);
            src = 6'h0E;
        end
        if (e[4:0] == 5'h00) begin
            repeat (40) @(negedge clk);
            check("core_reset", 16'h0000, {15'h0000, core_reset});
        end
        repeat (2000) if (q.size() != 0) @(negedge clk);
        $display("test with sources %h done", s);
    endtask : req

    // Count ticks and clocks per sequence, compare at release
    always @(posedge clk) begin
        if (rst || src[5:1] != 5'h07 || dbg[1]) begin
            ticks = 0;
            clks = 0;
        end else if (!sys_en && tick) ticks++;
        else if (sys_en && core_reset && !rd_en) clks++;
        if (pc_load === 1'b1) begin
            if (q.size() == 0) check("queue", 16'h0001, 16'h0000);
            else begin
                n = q.pop_front();
                check("ticks", n[22] ? 16'(NSYS) : 16'(NSHORT), 16'(ticks));
                check("sys_clks", 16'(NCLK), 16'(clks));
                check("system", {15'h0000, n[22]}, {15'h0000, is_sys});
                if (n[20:16] != 5'h1F) check("cause", {11'h000, n[20:16]}, {11'h000, cause});
                check("pc", n[15:0], pc_value);
            end
        end
    end

    // Main sequence
    initial begin
        void'($urandom(43410));
        q.push_back({2'h2, 5'h10, 16'h1234});
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (2000) if (q.size() != 0) @(negedge clk);
        for (int i = 0; i < 9; i++) req(srcs[i], exps[i], 1'b0);
        req(6'h0A, 7'h5F, 1'b1);
        check("pending", 16'h0000, 16'(q.size()));
        end_sim();
    end

    // Hang guard
    initial begin
        #40000;
        errors++;
        end_sim();
    end
endmodule : reset_sequencer_tb
